/* rtl/cpsf_flag_if.sv */
/*
 * Carrier between the flags register and its next-value logic.
 * Assumes both ends run on the same clock; the bundle is purely combinational.
 */
`timescale 1ns/1ps
interface cpsf_flag_if;
   import cpsf_pkg::*;

   logic [7:0] cur;
   logic [7:0] nxt;
   logic core_wr;
   logic [7:0] core_wdata;
   logic [2:0] flag_mask;
   logic alu_zero;
   logic alu_carry;
   logic alu_nibble_carry;
   logic alu_is_sub;
   logic clear_file_op;
   logic bus_wr;
   logic [7:0] bus_wdata;
   logic rc_load;
   logic [1:0] rc_value;

   modport owner (
      output cur,
      output core_wr,
      output core_wdata,
      output flag_mask,
      output alu_zero,
      output alu_carry,
      output alu_nibble_carry,
      output alu_is_sub,
      output clear_file_op,
      output bus_wr,
      output bus_wdata,
      output rc_load,
      output rc_value,
      input nxt
   );

   modport calc (
      input cur,
      input core_wr,
      input core_wdata,
      input flag_mask,
      input alu_zero,
      input alu_carry,
      input alu_nibble_carry,
      input alu_is_sub,
      input clear_file_op,
      input bus_wr,
      input bus_wdata,
      input rc_load,
      input rc_value,
      output nxt
   );

endinterface

/* rtl/cpsf_flag_next.sv */
/*
 * Next-value logic of the processor flags register.
 * Assumes the owner holds the register and feeds back its current value.
 */
`timescale 1ns/1ps
module cpsf_flag_next (
   // Bundle from the register owner
   cpsf_flag_if.calc fl
);
   import cpsf_pkg::*;

   // ************************************************************
   // Flag logic results
   // ************************************************************
   // A subtract stores the inverted borrow, which a raw carry out of a + ~b + 1 would already be;
   // the ALU reports the true borrow on subtract, hence the inversion here.
   wire store_cy = fl.alu_is_sub ? ~fl.alu_carry : fl.alu_carry;
   wire store_dc = fl.alu_is_sub ? ~fl.alu_nibble_carry : fl.alu_nibble_carry;
   wire [7:0] flag_val = {5'h00, fl.alu_zero, store_dc, store_cy};
   wire [7:0] flag_sel = {5'h00, fl.flag_mask};

   // ************************************************************
   // Write sources
   // ************************************************************
   // Bus write first, instruction write over it: the core wins a same-cycle collision.
   wire [7:0] after_bus = fl.bus_wr ? fl.bus_wdata : fl.cur;
   wire [7:0] after_core = fl.core_wr ? fl.core_wdata : after_bus;
   // Clear-file on this register: bank bits clear, zero sets, the rest stay.
   wire [7:0] clr_val = (fl.cur & ~CPSF_BANK_MASK) | (8'h01 << CPSF_BIT_ZERO);
   wire [7:0] written = fl.clear_file_op ? clr_val : after_core;
   // Flag-producing instructions override whatever the write put in those bits.
   wire [7:0] with_flags = (written & ~flag_sel) | (flag_val & flag_sel);
   // Reset-cause bits ignore every write and change only from the reset logic.
   wire [7:0] rc_bits = fl.rc_load ? {3'h0, fl.rc_value, 3'h0} : (fl.cur & CPSF_RESET_CAUSE_MASK);

   assign fl.nxt = (with_flags & ~CPSF_RESET_CAUSE_MASK) | rc_bits;

endmodule

/* rtl/cpsf_flags_reg.sv */
/*
 * Processor flags register with APB access and bank-select address forming.
 * Assumes instruction execution drives the core strobes for one cycle per
 * executed instruction, synchronous to clk, and an APB master on the bus side.
 */
// What this block does
// - The flags register accepts instruction writes like any other data register, within the bit limits below.
// - When a flag-producing instruction writes the register, zero, nibble borrow and borrow come from the flag logic.
// - The watchdog expiry and sleep flags ignore writes and read as one after power-on reset.
// - Layout from bit 7 is indirect bank high, bank select high and low, watchdog, sleep, zero, nibble borrow, borrow.
// - Clear-file on the register clears the three bank bits, sets zero and leaves the other bits alone.
// - On subtraction borrow and nibble borrow hold inverted borrows of the byte and the low nibble.
// - The bank bits choose which data-memory bank the direct and indirect paths reach.
`timescale 1ns/1ps
module cpsf_flags_reg #(
   parameter int unsigned DIR_AW = cpsf_pkg::CPSF_DIR_AW,
   parameter int unsigned IND_AW = cpsf_pkg::CPSF_IND_AW
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cpsf_pkg::CPSF_APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction execution
   input wire logic core_wr,
   input wire logic [cpsf_pkg::CPSF_W-1:0] core_wdata,
   input wire logic [2:0] flag_mask,
   input wire logic alu_zero,
   input wire logic alu_carry,
   input wire logic alu_nibble_carry,
   input wire logic alu_is_sub,
   input wire logic clear_file_op,
   // Reset-cause logic
   input wire logic rc_load,
   input wire logic watchdog_expiry_src,
   input wire logic sleep_src,
   // Data memory addressing
   input wire logic [DIR_AW-1:0] dir_addr,
   input wire logic [IND_AW-1:0] ind_ptr,
   output logic [DIR_AW+1:0] dir_mem_addr,
   output logic [IND_AW:0] ind_mem_addr,
   // Register view
   output logic [cpsf_pkg::CPSF_W-1:0] processor_flags
);
   import cpsf_pkg::*;

   // ************************************************************
   // Parameter checks
   // ************************************************************
   // The bank bits are prepended to both addresses, so each width must leave room for them.
   if (DIR_AW < 1 || DIR_AW > 16) begin : g_bad_dir_aw
      $error("cpsf_flags_reg: DIR_AW must lie in 1..16");
   end
   if (IND_AW < 1 || IND_AW > 16) begin : g_bad_ind_aw
      $error("cpsf_flags_reg: IND_AW must lie in 1..16");
   end

   // ************************************************************
   // State
   // ************************************************************
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   // One-hot states of the bus answer sequencer.
   typedef enum logic [1:0] {
      CPSF_RSP_IDLE = 2'b01,
      CPSF_RSP_ANSWER = 2'b10
   } cpsf_rsp_t;
   cpsf_rsp_t rsp_q;
   cpsf_rsp_t rsp_d;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [DIR_AW+1:0] dir_mem_addr_q;
   logic [IND_AW:0] ind_mem_addr_q;

   // ************************************************************
   // APB decode
   // ************************************************************
   // Zero-wait answer one cycle after setup: response is prepared during setup so
   // every bus output can come straight from a flop.
   wire setup_ph = psel & ~penable;
   wire hit = (paddr == CPSF_OFS_PROCESSOR_FLAGS);
   wire answer_d = (rsp_d == CPSF_RSP_ANSWER);
   // The write lands only at the edge that completes the access, never during setup.
   wire bus_wr = psel & penable & pready_q & pwrite & hit;
   wire [31:0] rd_word = hit ? {24'h000000, flags_q} : 32'h00000000;
   wire pslverr_d = answer_d & ~hit;
   wire [31:0] prdata_d = (answer_d & ~pwrite) ? rd_word : 32'h00000000;

   // A setup is answered only from idle, so a master that drops penable in the
   // middle of an access cannot stretch one answer into two.
   always_comb begin
      rsp_d = CPSF_RSP_IDLE;
      unique case (rsp_q)
         CPSF_RSP_IDLE: begin
            rsp_d = setup_ph ? CPSF_RSP_ANSWER : CPSF_RSP_IDLE;
         end
         CPSF_RSP_ANSWER: begin
            rsp_d = CPSF_RSP_IDLE;
         end
      endcase
   end

   // ************************************************************
   // Next-value logic
   // ************************************************************
   cpsf_flag_if fl ();

   assign fl.cur = flags_q;
   assign fl.core_wr = core_wr;
   assign fl.core_wdata = core_wdata;
   assign fl.flag_mask = flag_mask;
   assign fl.alu_zero = alu_zero;
   assign fl.alu_carry = alu_carry;
   assign fl.alu_nibble_carry = alu_nibble_carry;
   assign fl.alu_is_sub = alu_is_sub;
   assign fl.clear_file_op = clear_file_op;
   assign fl.bus_wr = bus_wr;
   assign fl.bus_wdata = pwdata[7:0];
   assign fl.rc_load = rc_load;
   assign fl.rc_value = {watchdog_expiry_src, sleep_src};
   assign flags_d = fl.nxt;

   cpsf_flag_next u_next (
      .fl(fl.calc)
   );

   // ************************************************************
   // Bank-select address forming
   // ************************************************************
   wire bank_sel_hi = flags_q[CPSF_BIT_BANK_SEL_HI];
   wire bank_sel_lo = flags_q[CPSF_BIT_BANK_SEL_LO];
   wire indirect_bank_high = flags_q[CPSF_BIT_INDIRECT_BANK_HIGH];
   // Four direct banks of 2**DIR_AW registers each; the indirect path reaches two
   // halves of its space through the one extra pointer bit.
   wire [DIR_AW+1:0] dir_next = {bank_sel_hi, bank_sel_lo, dir_addr};
   wire [IND_AW:0] ind_next = {indirect_bank_high, ind_ptr};

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_q <= CPSF_RESET_VALUE;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_q <= CPSF_RSP_IDLE;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   // The answer flops load from the sequencer's next state, so pready stays a flop output.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= answer_d;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= pslverr_d;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= 32'h00000000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   // Addresses lag the flags by one cycle; a bank change is seen on the next access.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dir_mem_addr_q <= '0;
      end else begin
         dir_mem_addr_q <= dir_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ind_mem_addr_q <= '0;
      end else begin
         ind_mem_addr_q <= ind_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign dir_mem_addr = dir_mem_addr_q;
   assign ind_mem_addr = ind_mem_addr_q;
   assign processor_flags = flags_q;

endmodule

/* rtl/cpsf_pkg.sv */
/*
 * Shared constants for the processor flags register block: field positions,
 * reset values, bus offsets and widths.
 * Assumes a single 100 MHz core clock and an APB register bus with 32-bit data.
 */
package cpsf_pkg;

   // ************************************************************
   // Field positions of the processor flags register
   // ************************************************************
   localparam int unsigned CPSF_W = 8;
   localparam int unsigned CPSF_BIT_BORROW = 0;
   localparam int unsigned CPSF_BIT_NIBBLE_BORROW = 1;
   localparam int unsigned CPSF_BIT_ZERO = 2;
   localparam int unsigned CPSF_BIT_SLEEP_FLAG = 3;
   localparam int unsigned CPSF_BIT_WATCHDOG_EXPIRY_FLAG = 4;
   localparam int unsigned CPSF_BIT_BANK_SEL_LO = 5;
   localparam int unsigned CPSF_BIT_BANK_SEL_HI = 6;
   localparam int unsigned CPSF_BIT_INDIRECT_BANK_HIGH = 7;

   // ************************************************************
   // Masks and values after reset
   // ************************************************************
   localparam logic [7:0] CPSF_ARITH_MASK = 8'h07;
   localparam logic [7:0] CPSF_RESET_CAUSE_MASK = 8'h18;
   localparam logic [7:0] CPSF_BANK_MASK = 8'hE0;
   // Arithmetic flags are undefined at power-on; zero is used here.
   localparam logic [7:0] CPSF_RESET_VALUE = 8'h18;

   // ************************************************************
   // Register bus
   // ************************************************************
   localparam int unsigned CPSF_APB_AW = 8;
   localparam logic [7:0] CPSF_OFS_PROCESSOR_FLAGS = 8'h00;

   // ************************************************************
   // Data memory addressing widths
   // ************************************************************
   localparam int unsigned CPSF_DIR_AW = 7;
   localparam int unsigned CPSF_IND_AW = 8;

endpackage

/* test/cpsf_core_model.sv */
/* Model of instruction execution driving the core strobes of the flags register.
   Assumes the bench changes its request inputs right after a rising clock edge. */
`timescale 1ns/1ps
module cpsf_core_model (
   // Request: kind 0 move, 1 subtract, 2 add, 3 clear-file
   input wire logic go, input wire logic [1:0] kind, input wire logic [7:0] data, input wire logic [2:0] res,
   // Strobes towards the flags register
   output logic core_wr, output logic [7:0] core_wdata, output logic [2:0] flag_mask,
   output logic alu_zero, output logic alu_carry, output logic alu_nibble_carry,
   output logic alu_is_sub, output logic clear_file_op
);
   assign core_wr = go && kind != 2'h3;
   // Idle data shows the inverse, so a stale value is never taken for a write.
   assign core_wdata = go ? data : ~data;
   assign flag_mask = (go && (kind == 2'h1 || kind == 2'h2)) ? 3'h7 : 3'h0;
   assign alu_is_sub = go && kind == 2'h1;
   assign {alu_zero, alu_nibble_carry, alu_carry} = res;
   assign clear_file_op = go && kind == 2'h3;
endmodule

/* test/cpsf_flags_reg_monitor.sv */
/* Concurrent checks on the ports of the processor flags register.
   Assumes one clock domain; bound to every cpsf_flags_reg instance. */
`timescale 1ns/1ps
module cpsf_flags_reg_monitor #(parameter int unsigned DIR_AW = 7) (
   // Clock, reset and APB
   input wire logic clk, input wire logic rst_b,
   input wire logic psel, input wire logic penable, input wire logic [7:0] paddr,
   input wire logic pready, input wire logic pslverr,
   // Core side
   input wire logic core_wr, input wire logic [7:0] core_wdata, input wire logic [2:0] flag_mask,
   input wire logic alu_zero, input wire logic alu_carry, input wire logic alu_is_sub,
   input wire logic clear_file_op, input wire logic rc_load,
   input wire logic watchdog_expiry_src, input wire logic sleep_src,
   // Addressing and register view
   input wire logic [DIR_AW-1:0] dir_addr, input wire logic [DIR_AW+1:0] dir_mem_addr,
   input wire logic [7:0] processor_flags
);
   wire [7:0] f = processor_flags;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_rc_hold; !rc_load |=> f[4:3] == $past(f[4:3]); endproperty
   a_rc_hold: assert property (p_rc_hold) else $error("reset cause bits changed");
   property p_rc_load; rc_load |=> f[4:3] == $past({watchdog_expiry_src, sleep_src}); endproperty
   a_rc_load: assert property (p_rc_load) else $error("reset cause load wrong");
   property p_clear;
      clear_file_op && !core_wr && flag_mask == 3'h0 && !rc_load |=> f[7:5] == 3'h0 && f[2] && f[1:0] == $past(f[1:0]);
   endproperty
   a_clear: assert property (p_clear) else $error("clear file result wrong");
   property p_zero; flag_mask[2] |=> f[2] == $past(alu_zero); endproperty
   a_zero: assert property (p_zero) else $error("zero flag not from flag logic");
   property p_borrow; flag_mask[0] |=> f[0] == $past(alu_carry ^ alu_is_sub); endproperty
   a_borrow: assert property (p_borrow) else $error("borrow flag wrong");
   property p_wr; core_wr && !clear_file_op |=> f[7:5] == $past(core_wdata[7:5]); endproperty
   a_wr: assert property (p_wr) else $error("core write lost");
   property p_dir; $past(rst_b) |-> dir_mem_addr == {$past(f[6:5]), $past(dir_addr)}; endproperty
   a_dir: assert property (p_dir) else $error("direct bank address wrong");
   property p_ready; psel && !penable |=> pready && pslverr == ($past(paddr) != 8'h00); endproperty
   a_ready: assert property (p_ready) else $error("bus answer wrong");
endmodule
bind cpsf_flags_reg cpsf_flags_reg_monitor #(.DIR_AW(DIR_AW)) cpsf_flags_reg_monitor_i (
   .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .core_wr(core_wr), .core_wdata(core_wdata), .flag_mask(flag_mask),
   .alu_zero(alu_zero), .alu_carry(alu_carry), .alu_is_sub(alu_is_sub), .clear_file_op(clear_file_op),
   .rc_load(rc_load), .watchdog_expiry_src(watchdog_expiry_src), .sleep_src(sleep_src),
   .dir_addr(dir_addr), .dir_mem_addr(dir_mem_addr), .processor_flags(processor_flags));

/* test/cpsf_tb.sv */
/* Self-checking bench of the flags register: APB master, core model, random ops.
   Assumes the monitor is bound to the design. */
`timescale 1ns/1ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin fails++; $display("MISMATCH %0t %h %h", $time, g, x); end end
module testbench;
   import cpsf_pkg::*;
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, go = 0, rc_load = 0, wd = 0, sl = 0;
   logic [7:0] paddr = 8'h00, data = 8'h00, ind_ptr = 8'h00, exp_q, core_wdata, processor_flags;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [1:0] kind = 2'h0;
   logic [2:0] res = 3'h0, flag_mask;
   logic [6:0] dir_addr = 7'h00;
   logic [8:0] dir_mem_addr, ind_mem_addr;
   logic pready, pslverr, e, core_wr, alu_zero, alu_carry, alu_nibble_carry, alu_is_sub, clear_file_op;
   int fails = 0, compares = 0;
   always #5 clk = ~clk;
   cpsf_core_model cpsf_core_model_i (.go(go), .kind(kind), .data(data), .res(res), .core_wr(core_wr),
      .core_wdata(core_wdata), .flag_mask(flag_mask), .alu_zero(alu_zero), .alu_carry(alu_carry),
      .alu_nibble_carry(alu_nibble_carry), .alu_is_sub(alu_is_sub), .clear_file_op(clear_file_op));
   cpsf_flags_reg cpsf_flags_reg_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_wr(core_wr),
      .core_wdata(core_wdata), .flag_mask(flag_mask), .alu_zero(alu_zero), .alu_carry(alu_carry),
      .alu_nibble_carry(alu_nibble_carry), .alu_is_sub(alu_is_sub), .clear_file_op(clear_file_op),
      .rc_load(rc_load), .watchdog_expiry_src(wd), .sleep_src(sl), .dir_addr(dir_addr), .ind_ptr(ind_ptr),
      .dir_mem_addr(dir_mem_addr), .ind_mem_addr(ind_mem_addr), .processor_flags(processor_flags));
   function automatic logic [7:0] nf(logic [7:0] c, logic [1:0] k, logic [7:0] d, logic [2:0] x);
      if (k == 2'h3) return {3'h0, c[4:3], 1'b1, c[1:0]};
      if (k == 2'h1) return {d[7:5], c[4:3], x[2], ~x[1:0]};
      return {d[7:5], c[4:3], (k == 2'h2) ? x : d[2:0]};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      if (w && a == 8'h00) exp_q = {d[7:5], exp_q[4:3], d[2:0]};
   endtask
   task automatic op(input logic [1:0] k, input logic [7:0] d);
      logic [7:0] n;
      logic [2:0] x, q;
      x = 3'($urandom);
      q = 3'($urandom);
      n = nf(exp_q, k, d, x);
      @(posedge clk);
      {go, kind, data, res, rc_load, wd, sl} <= {1'b1, k, d, x, q};
      dir_addr <= 7'($urandom);
      ind_ptr <= 8'($urandom);
      exp_q = q[2] ? {n[7:5], q[1:0], n[2:0]} : n;
   endtask
   task automatic summarize;
      if (fails == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      summarize;
   end
   initial begin
      void'($urandom(32'hCBE3F160));
      repeat (20) @(posedge clk);
      rst_b <= 1;
      exp_q = CPSF_RESET_VALUE;
      apb(0, CPSF_OFS_PROCESSOR_FLAGS, 32'h0);
      `CHK(r, 32'h00000018)
      apb(1, CPSF_OFS_PROCESSOR_FLAGS, 32'hFFFFFFFF);
      apb(0, CPSF_OFS_PROCESSOR_FLAGS, 32'h0);
      `CHK(r, 32'h000000FF)
      apb(1, 8'h04, 32'h0);
      `CHK(e, 1'b1)
      apb(0, 8'h04, 32'h0);
      `CHK({e, r}, {1'b1, 32'h0})
      for (int i = 0; i < 60; i++) op((i < 4) ? i[1:0] : 2'($urandom), (i < 4) ? 8'hFF : 8'($urandom));
      @(posedge clk);
      {go, rc_load} <= 2'h0;
      @(posedge clk);
      #1;
      `CHK(processor_flags, exp_q)
      `CHK(dir_mem_addr, {exp_q[6:5], dir_addr})
      `CHK(ind_mem_addr, {exp_q[7], ind_ptr})
      apb(0, CPSF_OFS_PROCESSOR_FLAGS, 32'h0);
      `CHK(r, {24'h0, exp_q})
      summarize;
   end
endmodule
